// ---- dv/host_write_model.sv ----
`timescale 1ns/1ns
//------------------------------------------------------------
// Host side of the register write port
//------------------------------------------------------------
module host_write_model (
    // Clock
    input  wire logic       clk,
    // Write port
    output      logic       wr_en,
    output      logic [7:0] wr_addr,
    output      logic [7:0] wr_data
);
    // Short gamma ramp ending at full scale
    localparam logic [7:0] GAMMA [4] = '{8'h00, 8'h04, 8'h12, 8'hff};

    // Idle port at time zero
    initial begin
        wr_en   = 1'b0;
        wr_addr = 8'h00;
        wr_data = 8'h00;
    end

    // One byte per cycle; back to back calls keep the strobe high
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr_en   = 1'b1;
        wr_addr = a;
        wr_data = d;
    endtask : write

    // Inverted lines after release, so no stale byte looks valid
    task automatic idle();
        @(negedge clk);
        wr_en   = 1'b0;
        wr_addr = ~wr_addr;
        wr_data = ~wr_data;
    endtask : idle

    // Breathing: each step made visible by an update write
    task automatic breathe(input logic [7:0] a);
        for (int i = 0; i < 4; i++) begin
            write(a, GAMMA[i]);
            write(led_pwm_pkg::ADDR_UPDATE, 8'h00);
        end
        idle();
    endtask : breathe
endmodule : host_write_model

// ---- dv/led_pwm_channel_core_tb.sv ----
`timescale 1ns/1ns
//------------------------------------------------------------
// Bench of the LED PWM channel core
//------------------------------------------------------------
module led_pwm_channel_core_tb;
    typedef struct { logic [7:0] addr; logic [7:0] data; logic [8:0] slots; } row_t;
    logic        clk;
    logic        rst_b;
    logic        pin_n;
    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [7:0]  wr_data;
    logic [17:0] led;
    logic        sd;
    int          fails;
    int          comparisons;
    int          cycles;
    logic [8:0]  got [18];
    logic [8:0]  exp [18];
    // Duty rows: boundary values on scattered channels, with lit slots per period
    row_t rows [6] = '{'{8'h01, 8'h00, 9'h000}, '{8'h02, 8'h01, 9'h001}, '{8'h05, 8'h04, 9'h004},
                       '{8'h08, 8'h80, 9'h080}, '{8'h0f, 8'hb5, 9'h0b5}, '{8'h12, 8'hff, 9'h0ff}};

    led_pwm_channel_core u_dut (.clk(clk), .rst_b(rst_b), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
                                .hw_shutdown_pin_n(pin_n), .led_channel_outputs(led), .shutdown_active(sd));
    host_write_model u_host (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));

    // Clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            fails++;
            summarize();
        end
    end

    task automatic summarize();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize

    task automatic check_vec(input logic [17:0] g, input logic [17:0] e);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check_vec

    // Counting on-slots over a full period is phase free of the counter
    task automatic measure();
        repeat (8) @(negedge clk);
        for (int i = 0; i < 18; i++) got[i] = 9'h000;
        repeat (256) begin
            @(negedge clk);
            for (int i = 0; i < 18; i++) got[i] += {8'h00, led[i]};
        end
    endtask : measure

    task automatic check_counts(input logic dark);
        measure();
        for (int i = 0; i < 18; i++) begin
            comparisons++;
            if (got[i] !== (dark ? 9'h000 : exp[i])) begin
                fails++;
                $display("mismatch at %0t: channel %0d on %0d slots", $time, i, got[i]);
            end
        end
    endtask : check_counts

    task automatic enable_all();
        for (int a = 8'h13; a <= 8'h15; a++) u_host.write(a[7:0], 8'hff);
        u_host.write(led_pwm_pkg::ADDR_UPDATE, 8'h5a);
        u_host.write(led_pwm_pkg::ADDR_SHUTDOWN, 8'h01);
        u_host.idle();
    endtask : enable_all

    // Main sequence
    initial begin
        rst_b = 1'b0;
        pin_n = 1'b1;
        for (int i = 0; i < 18; i++) exp[i] = 9'h000;
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst_b = 1'b1;
        check_vec(led, 18'h00000);
        check_vec({17'h0, sd}, 18'h1);
        foreach (rows[r]) begin
            u_host.write(rows[r].addr, rows[r].data);
            exp[rows[r].addr - 8'h01] = rows[r].slots;
        end
        enable_all();
        check_counts(1'b0);
        // Staged duty stays hidden until the update write
        u_host.write(8'h02, 8'h40);
        u_host.idle();
        check_counts(1'b0);
        u_host.breathe(8'h02);
        exp[1] = 9'h0ff;
        check_counts(1'b0);
        // Middle enable group off
        u_host.write(8'h14, 8'hc0);
        u_host.write(led_pwm_pkg::ADDR_UPDATE, 8'h00);
        u_host.write(8'h18, 8'hff);
        u_host.write(8'hff, 8'h00);
        u_host.idle();
        exp[7] = 9'h000;
        check_counts(1'b0);
        // Software shutdown and return
        u_host.write(led_pwm_pkg::ADDR_SHUTDOWN, 8'hfe);
        u_host.idle();
        check_counts(1'b1);
        check_vec({17'h0, sd}, 18'h1);
        u_host.write(led_pwm_pkg::ADDR_SHUTDOWN, 8'h01);
        u_host.idle();
        check_counts(1'b0);
        // Hardware shutdown overrides the run bit
        pin_n = 1'b0;
        check_counts(1'b1);
        check_vec({17'h0, sd}, 18'h1);
        pin_n = 1'b1;
        check_counts(1'b0);
        // Reset write clears duty and run bit
        u_host.write(led_pwm_pkg::ADDR_RESET, 8'ha5);
        u_host.idle();
        repeat (4) @(negedge clk);
        check_vec(led, 18'h00000);
        check_vec({17'h0, sd}, 18'h1);
        enable_all();
        check_counts(1'b1);
        summarize();
    end
endmodule : led_pwm_channel_core_tb

// ---- rtl/led_output_stage.sv ----
`timescale 1ns/1ns
module led_output_stage (
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           rst_b,
    // Applied settings
    pwm_ctl_if.dst              ctl,
    // Channel drive
    output      logic [17:0]    led_out
);

    logic [17:0] out_ff;
    logic [17:0] nxt_out;

    //------------------------------------------------------------
    // Per-channel comparators
    //------------------------------------------------------------
    // A duty of 0 never lights and 255 lights 255 of 256 slots
    for (genvar i = 0; i < led_pwm_pkg::NUM_CH; i++) begin : g_ch
        assign nxt_out[i] = (ctl.cnt < ctl.duty[i]) && ctl.en[i] && !ctl.off; // RL12 RL4 RL11
    end

    // Outputs registered so the pins never glitch on the compare
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_ff <= 18'h00000;
        end else begin
            out_ff <= nxt_out;
        end
    end

    assign led_out = out_ff;

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_out_off_shutdown: assert property (ctl.off |=> led_out == 18'h00000) // RL6
        else $error("Output lit during shutdown");
    a_out_duty_slot: assert property (!ctl.off && ctl.en[0]
        |=> led_out[0] == ($past(ctl.cnt) < $past(ctl.duty[0]))) // RL4
        else $error("Channel 0 output disagrees with duty compare");
    a_out_disabled: assert property (!ctl.en[17] |=> !led_out[17]) // RL11
        else $error("Disabled channel lit");

endmodule : led_output_stage

// ---- rtl/led_pwm_channel_core.sv ----
`timescale 1ns/1ns
module led_pwm_channel_core (
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           rst_b,
    // Register write port from the serial front end
    input  wire logic           wr_en,
    input  wire logic [7:0]     wr_addr,
    input  wire logic [7:0]     wr_data,
    // Shutdown pin
    input  wire logic           hw_shutdown_pin_n,
    // Channel drive and status
    output      logic [17:0]    led_channel_outputs,
    output      logic           shutdown_active
);

    pwm_ctl_if ctl ();

    logic              soft_run_ff,   nxt_soft_run;
    logic [17:0][7:0]  stage_duty_ff, nxt_stage_duty;
    logic [17:0]       stage_en_ff,   nxt_stage_en;
    logic [17:0][7:0]  duty_ff,       nxt_duty;
    logic [17:0]       en_ff,         nxt_en;
    logic [7:0]        cnt_ff,        nxt_cnt;
    logic              shutdown_ff,   nxt_shutdown;
    logic              sd_meta_ff;
    logic              sd_sync_ff;
    logic              first_ff;

    //------------------------------------------------------------
    // Register file
    //------------------------------------------------------------
    // Next values of staging, applied and shutdown state
    always_comb begin
        logic [4:0] base;
        base           = led_pwm_pkg::en_base(wr_addr);
        nxt_soft_run   = soft_run_ff;
        nxt_stage_duty = stage_duty_ff;
        nxt_stage_en   = stage_en_ff;
        nxt_duty       = duty_ff;
        nxt_en         = en_ff;
        // Writes land even in shutdown; shutdown only gates the drive
        if (wr_en) begin
            if (wr_addr == led_pwm_pkg::ADDR_RESET) begin
                // Data byte is ignored
                nxt_soft_run   = led_pwm_pkg::RUN_RST; // RL1
                nxt_stage_duty = {18{led_pwm_pkg::DUTY_RST}}; // RL1
                nxt_stage_en   = led_pwm_pkg::EN_RST; // RL1
                nxt_duty       = {18{led_pwm_pkg::DUTY_RST}}; // RL1
                nxt_en         = led_pwm_pkg::EN_RST; // RL1
            end else if (wr_addr == led_pwm_pkg::ADDR_UPDATE) begin
                nxt_duty = stage_duty_ff; // RL10
                nxt_en   = stage_en_ff; // RL10
            end else if (wr_addr == led_pwm_pkg::ADDR_SHUTDOWN) begin
                nxt_soft_run = wr_data[led_pwm_pkg::RUN_BIT]; // RL6
            end else if (wr_addr >= led_pwm_pkg::ADDR_DUTY_FIRST &&
                         wr_addr <= led_pwm_pkg::ADDR_DUTY_LAST) begin
                nxt_stage_duty[led_pwm_pkg::duty_index(wr_addr)] = wr_data; // RL3 RL10
            end else if (wr_addr >= led_pwm_pkg::ADDR_EN_FIRST &&
                         wr_addr <= led_pwm_pkg::ADDR_EN_LAST) begin
                // Bits 7:6 are reserved and dropped
                for (int k = 0; k < led_pwm_pkg::CH_PER_EN_REG; k++) begin
                    nxt_stage_en[base + 5'(k)] = wr_data[k]; // RL11
                end
            end
            // Unmapped addresses are ignored
        end
    end

    // Power-up loads the defaults: run bit clear, so display blank
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            soft_run_ff   <= led_pwm_pkg::RUN_RST; // RL2
            stage_duty_ff <= {18{led_pwm_pkg::DUTY_RST}};
            stage_en_ff   <= led_pwm_pkg::EN_RST;
            duty_ff       <= {18{led_pwm_pkg::DUTY_RST}}; // RL2
            en_ff         <= led_pwm_pkg::EN_RST;
        end else begin
            soft_run_ff   <= nxt_soft_run;
            stage_duty_ff <= nxt_stage_duty;
            stage_en_ff   <= nxt_stage_en;
            duty_ff       <= nxt_duty;
            en_ff         <= nxt_en;
        end
    end

    //------------------------------------------------------------
    // Shutdown pin synchroniser
    //------------------------------------------------------------
    // Pin is asynchronous; resets to low so the core starts dark
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sd_meta_ff <= 1'b0;
            sd_sync_ff <= 1'b0;
        end else begin
            sd_meta_ff <= hw_shutdown_pin_n;
            sd_sync_ff <= sd_meta_ff;
        end
    end

    //------------------------------------------------------------
    // Slot counter and shutdown state
    //------------------------------------------------------------
    // Counter runs on in shutdown; no phase to resume from
    always_comb begin
        nxt_cnt      = cnt_ff + led_pwm_pkg::CNT_STEP; // RL12
        nxt_shutdown = !soft_run_ff || !sd_sync_ff; // RL6 RL7
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff      <= led_pwm_pkg::CNT_RST;
            shutdown_ff <= 1'b1;
            first_ff    <= 1'b1;
        end else begin
            cnt_ff      <= nxt_cnt;
            shutdown_ff <= nxt_shutdown;
            first_ff    <= 1'b0;
        end
    end

    //------------------------------------------------------------
    // Output stage
    //------------------------------------------------------------
    assign ctl.cnt  = cnt_ff;
    assign ctl.duty = duty_ff;
    assign ctl.en   = en_ff;
    assign ctl.off  = shutdown_ff; // RL5

    led_output_stage u_stage (
        .clk     (clk),
        .rst_b   (rst_b),
        .ctl     (ctl.dst),
        .led_out (led_channel_outputs)
    );

    assign shutdown_active = shutdown_ff;

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_soft_off_write;
        wr_en && wr_addr == led_pwm_pkg::ADDR_SHUTDOWN && !wr_data[0];
    endsequence

    sequence s_run_clear_then_off;
        !soft_run_ff ##1 shutdown_ff;
    endsequence

    a_first_defaults: assert property (first_ff |-> duty_ff == '0 && en_ff == '0 && !soft_run_ff) // RL2
        else $error("Defaults missing after reset");
    a_reset_write: assert property (wr_en && wr_addr == led_pwm_pkg::ADDR_RESET
        |=> duty_ff == '0 && stage_duty_ff == '0 && en_ff == '0 && stage_en_ff == '0 && !soft_run_ff) // RL1
        else $error("Reset trigger did not restore defaults");
    a_duty_stage_write: assert property (wr_en && wr_addr == led_pwm_pkg::ADDR_DUTY_LAST
        |=> stage_duty_ff[17] == $past(wr_data)) // RL3
        else $error("Duty write not staged");
    a_duty_held: assert property (wr_en && wr_addr != led_pwm_pkg::ADDR_UPDATE
        && wr_addr != led_pwm_pkg::ADDR_RESET |=> duty_ff == $past(duty_ff) && en_ff == $past(en_ff)) // RL10
        else $error("Applied duty changed without update");
    a_update_applies: assert property (wr_en && wr_addr == led_pwm_pkg::ADDR_UPDATE
        |=> duty_ff == $past(stage_duty_ff) && en_ff == $past(stage_en_ff)) // RL10
        else $error("Update did not apply staging");
    a_enable_write: assert property (wr_en && wr_addr == led_pwm_pkg::ADDR_EN_LAST
        |=> stage_en_ff[17:12] == $past(wr_data[5:0])) // RL11
        else $error("Enable write misplaced");
    a_soft_shutdown: assert property (s_soft_off_write |=> s_run_clear_then_off) // RL6
        else $error("Software shutdown not entered");
    a_hw_shutdown: assert property ((!hw_shutdown_pin_n)[*3] |=> shutdown_ff) // RL7
        else $error("Hardware shutdown not entered");
    a_shutdown_keeps: assert property (shutdown_ff && !wr_en |=> duty_ff == $past(duty_ff)
        && stage_duty_ff == $past(stage_duty_ff)) // RL5
        else $error("Registers changed in shutdown");
    a_counter_wraps: assert property (cnt_ff == 8'hff |=> cnt_ff == 8'h00) // RL12
        else $error("Slot counter did not wrap");

endmodule : led_pwm_channel_core

// ---- rtl/led_pwm_pkg.sv ----
//------------------------------------------------------------
// Constants of the LED PWM channel core
//------------------------------------------------------------
// How it works
// (RL1) Any write to reset trigger restores defaults
// (RL2) Power-up loads defaults, display stays blank
// (RL3) Eighteen 8-bit duty registers, consecutive addresses
// (RL4) Duty is plain binary count of slots
// (RL5) Shutdown keeps every register value intact
// (RL6) Run bit cleared enters software shutdown
// (RL7) Low shutdown pin forces hardware shutdown
// (RL8) Host steps duty through gamma table
// (RL9) Host flashes or breathes by rewriting registers
// (RL10) Duty and enables staged until update write
// (RL11) Six enable bits per register, three registers
// (RL12) Shared counter below duty drives output
package led_pwm_pkg;

    localparam int          NUM_CH          = 18;
    localparam int          DUTY_W          = 8;
    localparam int          ADDR_W          = 8;
    localparam int          CH_PER_EN_REG   = 6;
    localparam int          RUN_BIT         = 0;

    // Register addresses
    localparam logic [7:0]  ADDR_SHUTDOWN   = 8'h00;
    localparam logic [7:0]  ADDR_DUTY_FIRST = 8'h01;
    localparam logic [7:0]  ADDR_DUTY_LAST  = 8'h12;
    localparam logic [7:0]  ADDR_EN_FIRST   = 8'h13;
    localparam logic [7:0]  ADDR_EN_LAST    = 8'h15;
    localparam logic [7:0]  ADDR_UPDATE     = 8'h16;
    localparam logic [7:0]  ADDR_RESET      = 8'h17;

    // Default values
    localparam logic [7:0]  DUTY_RST        = 8'h00;
    localparam logic [17:0] EN_RST          = 18'h00000;
    localparam logic        RUN_RST         = 1'b0;
    localparam logic [7:0]  CNT_RST         = 8'h00;
    localparam logic [7:0]  CNT_STEP        = 8'h01;

    // Channel index of a duty register address
    function automatic logic [4:0] duty_index(input logic [7:0] addr);
        logic [7:0] d;
        d = addr - ADDR_DUTY_FIRST;
        return d[4:0];
    endfunction : duty_index

    // First channel index covered by an enable register address
    function automatic logic [4:0] en_base(input logic [7:0] addr);
        logic [7:0] d;
        d = (addr - ADDR_EN_FIRST) * 8'h06;
        return d[4:0];
    endfunction : en_base

endpackage : led_pwm_pkg

// ---- rtl/pwm_ctl_if.sv ----
`timescale 1ns/1ns
// Applied channel settings passed from the register file to the output stage
interface pwm_ctl_if;
    logic [7:0]        cnt;
    logic [17:0][7:0]  duty;
    logic [17:0]       en;
    logic              off;

    modport src (output cnt, output duty, output en, output off);
    modport dst (input cnt, input duty, input en, input off);
endinterface : pwm_ctl_if
